// *** cfg_pkg.sv ***
// Summary of operation
// - Source pin low host, high memory
// - Memory source fetches image automatically
// - Image is 7424 bytes, byte writes
// - Each byte increments counter, reset zero
// - Load completes when counter reaches 7424
// - Last two bytes are CRC, compared
// - Check bit zero until end, then match
// - Bytes after 7424 are ignored
// - Host bytes ignored in memory mode
// - Counter and check report memory fetch
// - Host checks zero, writes, checks 0x01
// - 232 pages of 32, select max 0xE7
// - 32-byte buffer through one port
// - Host sets permit around page writes
// - Command bit 7 shows ready, poll
// - Command 0x00 clears bits, empties buffer
// - Command 0x01 writes buffer to page
// - Command 0x02 reads page into buffer
// - Host transfers whole pages only
// - Partial transfers discarded at next operation, except 0x01 keeps a partial buffer fill
package cfg_pkg;
	// ----------------------------------------
	// Device register map
	// ----------------------------------------
	localparam logic [7:0] REG_CFG_BYTE = 8'h30;
	localparam logic [7:0] REG_CNT_LO = 8'h31;
	localparam logic [7:0] REG_CNT_HI = 8'h32;
	localparam logic [7:0] REG_CHECK = 8'h33;
	localparam logic [7:0] REG_PERMIT = 8'h36;
	localparam logic [7:0] REG_CMD = 8'h37;
	localparam logic [7:0] REG_PAGE = 8'h38;
	localparam logic [7:0] REG_BUF = 8'h39;
	localparam logic [7:0] CMD_CLEAR = 8'h00;
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h02;
	localparam int READY_BIT = 7;
	// ----------------------------------------
	// Sizes and reset values
	// ----------------------------------------
	localparam logic [15:0] IMAGE_LEN = 16'h1D00;
	localparam logic [7:0] PAGE_MAX = 8'hE7;
	localparam logic [5:0] PAGE_BYTES = 6'h20;
	localparam logic [4:0] PAGE_LAST = 5'h1F;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [1:0] ARM_LAST = 2'h3;
	// ----------------------------------------
	// Host APB map
	// ----------------------------------------
	localparam logic [7:0] APB_ADDR = 8'h00;
	localparam logic [7:0] APB_WDATA = 8'h04;
	localparam logic [7:0] APB_GO = 8'h08;
	localparam logic [7:0] APB_STATUS = 8'h0C;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction
endpackage

// *** cfg_bus_if.sv ***
`timescale 1ns/10ps
// Request held until ack; ack is a one-cycle pulse
interface cfg_bus_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	modport host (output req, output we, output addr, output wdata, input rdata, input ack);
	modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface

// *** cfg_dev.sv ***
`timescale 1ns/10ps
module cfg_dev (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	cfg_bus_if.dev bus,
	input wire logic I_SRC_SEL,
	output logic O_MEM_REQ,
	output logic O_MEM_WE,
	output logic [12:0] O_MEM_ADDR,
	output logic [7:0] O_MEM_WDATA,
	input wire logic I_MEM_ACK,
	input wire logic [7:0] I_MEM_RDATA,
	output logic O_MEM_WP_N,
	output logic [7:0] O_CFG_BYTE,
	output logic O_CFG_STB,
	output logic O_CFG_DONE,
	output logic O_CFG_OK
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_INIT = 3'b000,
		ST_BOOT = 3'b001,
		ST_IDLE = 3'b010,
		ST_PGW = 3'b011,
		ST_PGR = 3'b100
	} state_t;

	typedef struct packed {
		state_t st;
		logic s1;
		logic s2;
		logic src;
		logic [1:0] arm;
		logic [15:0] cnt;
		logic [15:0] crc;
		logic [7:0] hi;
		logic ok;
		logic permit;
		logic [1:0] cmd;
		logic [7:0] page;
		logic [31:0][7:0] pbuf;
		logic [5:0] wp;
		logic [5:0] rp;
		logic [4:0] idx;
		logic mreq;
		logic mwe;
		logic [12:0] maddr;
		logic [7:0] mwd;
		logic ack;
		logic [7:0] rd;
		logic [7:0] cbyte;
		logic cstb;
	} dev_t;

	dev_t q;
	dev_t n;
	logic bv;
	logic [7:0] bd;
	logic ready;

	assign ready = (q.st == ST_IDLE);

	always_comb begin
		n = q;
		n.ack = 1'b0;
		n.cstb = 1'b0;
		n.s1 = I_SRC_SEL;
		n.s2 = q.s1;
		bv = 1'b0;
		bd = 8'h00;
		// ----------------------------------------
		// Engine
		// ----------------------------------------
		case (q.st)
			ST_INIT: begin
				// Wait for the synchroniser to fill before the pin is trusted
				n.arm = q.arm + 2'h1;
				if (q.arm == cfg_pkg::ARM_LAST) begin
					n.src = q.s2;
					n.st = q.s2 ? ST_BOOT : ST_IDLE;
				end
			end
			ST_BOOT: begin
				if (q.cnt == cfg_pkg::IMAGE_LEN) begin
					n.st = ST_IDLE;
				end else if (!q.mreq) begin
					n.mreq = 1'b1;
					n.mwe = 1'b0;
					n.maddr = q.cnt[12:0];
				end else if (I_MEM_ACK) begin
					n.mreq = 1'b0;
					bv = 1'b1;
					bd = I_MEM_RDATA;
				end
			end
			ST_PGW, ST_PGR: begin
				if (!q.mreq) begin
					n.mreq = 1'b1;
					n.mwe = (q.st == ST_PGW);
					n.maddr = {q.page, q.idx};
					n.mwd = q.pbuf[q.idx];
				end else if (I_MEM_ACK) begin
					n.mreq = 1'b0;
					n.idx = q.idx + 5'h1;
					if (q.st == ST_PGR) begin
						n.pbuf[q.idx] = I_MEM_RDATA;
					end
					if (q.idx == cfg_pkg::PAGE_LAST) begin
						n.st = ST_IDLE;
						n.cmd = 2'h0;
						if (q.st == ST_PGR) begin
							n.wp = cfg_pkg::PAGE_BYTES;
						end
					end
				end
			end
			default: begin
			end
		endcase
		// ----------------------------------------
		// Register port
		// ----------------------------------------
		if (bus.req && !q.ack) begin
			n.ack = 1'b1;
			n.rd = 8'h00;
			if (bus.we) begin
				case (bus.addr)
					cfg_pkg::REG_CFG_BYTE: begin
						// Host bytes only count in host mode after arming
						if (q.st != ST_INIT && !q.src) begin
							bv = 1'b1;
							bd = bus.wdata;
						end
					end
					cfg_pkg::REG_PERMIT: n.permit = bus.wdata[0];
					cfg_pkg::REG_CMD: begin
						if (ready) begin
							if (bus.wdata == cfg_pkg::CMD_CLEAR) begin
								n.cmd = 2'h0;
								n.wp = 6'h00;
								n.rp = 6'h00;
							end else if (bus.wdata == cfg_pkg::CMD_WRITE && q.permit) begin
								n.cmd = 2'h1;
								n.st = ST_PGW;
								n.idx = 5'h00;
								n.rp = 6'h00;
							end else if (bus.wdata == cfg_pkg::CMD_READ) begin
								n.cmd = 2'h2;
								n.st = ST_PGR;
								n.idx = 5'h00;
								n.wp = 6'h00;
								n.rp = 6'h00;
							end
						end
					end
					cfg_pkg::REG_PAGE: begin
						if (bus.wdata <= cfg_pkg::PAGE_MAX) begin
							n.page = bus.wdata;
						end
					end
					cfg_pkg::REG_BUF: begin
						if (ready && q.wp != cfg_pkg::PAGE_BYTES) begin
							n.pbuf[q.wp[4:0]] = bus.wdata;
							n.wp = q.wp + 6'h1;
						end
					end
					default: begin
					end
				endcase
			end else begin
				case (bus.addr)
					// Counter reads back as 0x1D/0x00 at completion
					cfg_pkg::REG_CNT_LO: n.rd = q.cnt[15:8];
					cfg_pkg::REG_CNT_HI: n.rd = q.cnt[7:0];
					cfg_pkg::REG_CHECK: n.rd = {7'h00, q.ok};
					cfg_pkg::REG_PERMIT: n.rd = {7'h00, q.permit};
					cfg_pkg::REG_CMD: n.rd = {ready, 5'h00, q.cmd};
					cfg_pkg::REG_PAGE: n.rd = q.page;
					cfg_pkg::REG_BUF: begin
						if (ready && q.rp < q.wp) begin
							n.rd = q.pbuf[q.rp[4:0]];
							n.rp = q.rp + 6'h1;
						end
					end
					default: n.rd = 8'h00;
				endcase
			end
		end
		// ----------------------------------------
		// Image loader, shared by both sources
		// ----------------------------------------
		if (bv && q.cnt != cfg_pkg::IMAGE_LEN) begin
			n.cnt = q.cnt + 16'h1;
			n.cbyte = bd;
			n.cstb = 1'b1;
			if (q.cnt < cfg_pkg::IMAGE_LEN - 16'h2) begin
				n.crc = cfg_pkg::crc_step(q.crc, bd);
			end else if (q.cnt == cfg_pkg::IMAGE_LEN - 16'h2) begin
				n.hi = bd;
			end else begin
				n.ok = ({q.hi, bd} == q.crc);
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			q <= '0;
			q.st <= ST_INIT;
			q.crc <= cfg_pkg::CRC_INIT;
		end else begin
			q <= n;
		end
	end

	assign bus.ack = q.ack;
	assign bus.rdata = q.rd;
	assign O_MEM_REQ = q.mreq;
	assign O_MEM_WE = q.mwe;
	assign O_MEM_ADDR = q.maddr;
	assign O_MEM_WDATA = q.mwd;
	assign O_MEM_WP_N = q.permit;
	assign O_CFG_BYTE = q.cbyte;
	assign O_CFG_STB = q.cstb;
	assign O_CFG_DONE = (q.cnt == cfg_pkg::IMAGE_LEN);
	assign O_CFG_OK = q.ok;
endmodule // cfg_dev

// *** cfg_host.sv ***
`timescale 1ns/10ps
module cfg_host (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	cfg_bus_if.host bus,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR
);
	typedef enum logic [0:0] {
		HS_IDLE = 1'b0,
		HS_WAIT = 1'b1
	} hstate_t;

	typedef struct packed {
		hstate_t st;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic we;
		logic [31:0] prd;
	} host_t;

	host_t q;
	host_t n;
	logic mapped;

	assign mapped = (I_PADDR == cfg_pkg::APB_ADDR) || (I_PADDR == cfg_pkg::APB_WDATA)
		|| (I_PADDR == cfg_pkg::APB_GO) || (I_PADDR == cfg_pkg::APB_STATUS);

	always_comb begin
		n = q;
		// ----------------------------------------
		// APB slave
		// ----------------------------------------
		// Read data is latched in the setup cycle so the access cycle can answer at once
		if (I_PSEL && !I_PENABLE) begin
			case (I_PADDR)
				cfg_pkg::APB_ADDR: n.prd = {24'h000000, q.addr};
				cfg_pkg::APB_WDATA: n.prd = {24'h000000, q.wdata};
				cfg_pkg::APB_STATUS: n.prd = {16'h0000, q.rdata, 7'h00, q.st == HS_WAIT};
				default: n.prd = 32'h00000000;
			endcase
		end
		if (I_PSEL && I_PENABLE && I_PWRITE) begin
			case (I_PADDR)
				cfg_pkg::APB_ADDR: n.addr = I_PWDATA[7:0];
				cfg_pkg::APB_WDATA: n.wdata = I_PWDATA[7:0];
				cfg_pkg::APB_GO: begin
					// A new order while one is in flight is dropped
					if (q.st == HS_IDLE && I_PWDATA[0]) begin
						n.st = HS_WAIT;
						n.we = I_PWDATA[1];
					end
				end
				default: begin
				end
			endcase
		end
		// ----------------------------------------
		// Device bus master
		// ----------------------------------------
		case (q.st)
			HS_WAIT: begin
				if (bus.ack) begin
					n.st = HS_IDLE;
					if (!q.we) begin
						n.rdata = bus.rdata;
					end
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			q <= '0;
			q.st <= HS_IDLE;
		end else begin
			q <= n;
		end
	end

	assign bus.req = (q.st == HS_WAIT);
	assign bus.we = q.we;
	assign bus.addr = q.addr;
	assign bus.wdata = q.wdata;
	assign O_PRDATA = q.prd;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
endmodule // cfg_host

// *** cfg_chk_props.sv ***
`timescale 1ns/10ps
module cfg_chk (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic O_MEM_REQ,
	input wire logic O_MEM_WE,
	input wire logic [12:0] O_MEM_ADDR,
	input wire logic I_MEM_ACK,
	input wire logic O_MEM_WP_N,
	input wire logic O_CFG_DONE,
	input wire logic O_CFG_OK
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	// ----
	// Bus and load
	// ----
	property p_ack; req && !ack |=> ack; endproperty
	a_ack: assert property (p_ack) else $error("access not acknowledged");
	property p_lo; ack && !we && addr == cfg_pkg::REG_CNT_LO && $past(O_CFG_DONE) |-> rdata == 8'h1D; endproperty
	a_lo: assert property (p_lo) else $error("final count wrong");
	property p_done; O_CFG_DONE |=> O_CFG_DONE; endproperty
	a_done: assert property (p_done) else $error("load completion lost");
	property p_ok; O_CFG_OK |-> O_CFG_DONE; endproperty
	a_ok: assert property (p_ok) else $error("check valid before completion");
	property p_chk; ack && !we && addr == cfg_pkg::REG_CHECK && $stable(O_CFG_OK) |-> rdata == {7'h00, O_CFG_OK}; endproperty
	a_chk: assert property (p_chk) else $error("check register mismatch");
	// ----
	// Memory port
	// ----
	property p_hold; O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WE); endproperty
	a_hold: assert property (p_hold) else $error("memory request dropped early");
	property p_drop; I_MEM_ACK |=> !O_MEM_REQ; endproperty
	a_drop: assert property (p_drop) else $error("memory request held after ack");
	property p_wp; O_MEM_REQ && O_MEM_WE |-> O_MEM_WP_N; endproperty
	a_wp: assert property (p_wp) else $error("memory write without permit");
	c_good: cover property (O_CFG_DONE && O_CFG_OK);
	c_bad: cover property (O_CFG_DONE && !O_CFG_OK);
	c_wr: cover property (O_MEM_REQ && O_MEM_WE && I_MEM_ACK);
endmodule // cfg_chk

// *** config_pump_and_nvm_page_access_tb.sv ***
`timescale 1ns/10ps
module config_pump_and_nvm_page_access_tb;
	logic clk = 1'b0, rst_n = 1'b0, src = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, mack = 1'b0;
	logic pready, slverr, se, mreq, mwe, wpn, done, ok, cs;
	logic [7:0] paddr = 8'h00, mrd = 8'h00, v, cur, mwd, cb, mem[8192], q[$];
	logic [31:0] pwd = 32'h0, prd, rv;
	logic [12:0] ma;
	logic [15:0] c;
	int fails = 0, num_checks = 0, dly = 0, n, ix = 0;
	always #5 clk = ~clk;
	cfg_bus_if bus();
	cfg_dev i_cfg_dev (.I_CORE_CLK(clk), .I_RST_N(rst_n), .bus(bus), .I_SRC_SEL(src), .O_MEM_REQ(mreq), .O_MEM_WE(mwe),
		.O_MEM_ADDR(ma), .O_MEM_WDATA(mwd), .I_MEM_ACK(mack), .I_MEM_RDATA(mrd), .O_MEM_WP_N(wpn), .O_CFG_BYTE(cb),
		.O_CFG_STB(cs), .O_CFG_DONE(done), .O_CFG_OK(ok));
	cfg_host i_cfg_host (.I_CORE_CLK(clk), .I_RST_N(rst_n), .bus(bus), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(pready), .O_PSLVERR(slverr));
	cfg_chk i_cfg_chk (.I_CORE_CLK(clk), .I_RST_N(rst_n), .req(bus.req), .we(bus.we), .addr(bus.addr),
		.rdata(bus.rdata), .ack(bus.ack), .O_MEM_REQ(mreq), .O_MEM_WE(mwe), .O_MEM_ADDR(ma), .I_MEM_ACK(mack),
		.O_MEM_WP_N(wpn), .O_CFG_DONE(done), .O_CFG_OK(ok));
	// ----
	// Serial memory stand-in
	// ----
	// Read data scrambles between answers so a stale byte cannot pass
	always @(posedge clk) begin
		if (mreq && !mack && dly == 0) begin
			mack <= 1'b1;
			dly <= $urandom_range(1, 0);
			if (mwe) mem[ma] <= mwd;
			mrd <= mwe ? ~mrd : mem[ma];
		end else begin
			mack <= 1'b0;
			mrd <= ~mrd;
			if (mreq && !mack && dly > 0) dly <= dly - 1;
		end
	end
	// ----
	// Tasks
	// ----
	task automatic finish_test();
		$display("Checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic to();
		fails++;
		$display("Error at %0t: wait ran out", $time);
		finish_test();
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] crc(input logic [15:0] r, input logic [7:0] d);
		for (int i = 7; i >= 0; i--) r = (r[15] ^ d[i]) ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
		return r;
	endfunction
	// Back-to-back transfers keep psel high; only reset releases it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		paddr <= a;
		pwr <= w;
		pwd <= d;
		psel <= 1'b1;
		pen <= 1'b0;
		@(posedge clk);
		pen <= 1'b1;
		do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 9);
		if (pready !== 1'b1) to();
		rv = prd;
		se = slverr;
	endtask
	task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k = 0;
		if (a !== cur) apb(1'b1, cfg_pkg::APB_ADDR, {24'h0, a});
		cur = a;
		if (w) apb(1'b1, cfg_pkg::APB_WDATA, {24'h0, d});
		apb(1'b1, cfg_pkg::APB_GO, {30'h0, w, 1'b1});
		do begin apb(1'b0, cfg_pkg::APB_STATUS, 32'h0); k++; end while (rv[0] !== 1'b0 && k < 9);
		if (rv[0] !== 1'b0) to();
		v = rv[15:8];
	endtask
	task automatic rdy();
		int k = 0;
		do begin dev(1'b0, cfg_pkg::REG_CMD, 8'h00); k++; end while (v[cfg_pkg::READY_BIT] !== 1'b1 && k < 99);
		if (v[cfg_pkg::READY_BIT] !== 1'b1) to();
		chk(v & 8'h83, 8'h80);
	endtask
	task automatic rst(input logic s);
		rst_n <= 1'b0;
		psel <= 1'b0;
		pen <= 1'b0;
		src <= s;
		ix = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		cur = 8'hFF;
		@(posedge clk);
	endtask
	// Every accepted image byte must match the model image, in order and no more
	always @(negedge clk) begin
		if (cs === 1'b1) begin
			chk(cb, mem[ix]);
			ix++;
		end
	end
	initial begin
		void'($urandom(32'h5223AE57));
		c = 16'hFFFF;
		for (int i = 0; i < 7424; i++) begin
			mem[i] = (i < 7422) ? 8'($urandom) : ((i == 7422) ? c[15:8] : ~c[7:0]);
			if (i < 7422) c = crc(c, mem[i]);
		end
		rst(1'b1);
		dev(1'b1, cfg_pkg::REG_CFG_BYTE, 8'h00);
		n = 0;
		while (done !== 1'b1 && n < 60000) begin @(posedge clk); n++; end
		if (done !== 1'b1) to();
		dev(1'b1, cfg_pkg::REG_CFG_BYTE, 8'h00);
		chk({7'h00, ix == 7424}, 8'h01);
		dev(1'b0, cfg_pkg::REG_CNT_LO, 8'h00);
		chk(v, 8'h1D);
		dev(1'b0, cfg_pkg::REG_CHECK, 8'h00);
		chk(v, 8'h00);
		mem[7423] = c[7:0];
		rst(1'b0);
		dev(1'b0, cfg_pkg::REG_CNT_LO, 8'h00);
		chk(v, 8'h00);
		dev(1'b0, cfg_pkg::REG_CNT_HI, 8'h00);
		chk(v, 8'h00);
		dev(1'b0, cfg_pkg::REG_CHECK, 8'h00);
		chk(v, 8'h00);
		for (int i = 0; i < 7425; i++) begin
			dev(1'b1, cfg_pkg::REG_CFG_BYTE, mem[i % 7424]);
			if (i == 299 || i == 7424) begin
				dev(1'b0, cfg_pkg::REG_CNT_HI, 8'h00);
				chk(v, (i == 299) ? 8'h2C : 8'h00);
			end
		end
		dev(1'b0, cfg_pkg::REG_CNT_LO, 8'h00);
		chk(v, 8'h1D);
		dev(1'b0, cfg_pkg::REG_CHECK, 8'h00);
		chk(v, 8'h01);
		chk({7'h00, ok}, 8'h01);
		chk({7'h00, ix == 7424}, 8'h01);
		dev(1'b1, cfg_pkg::REG_PERMIT, 8'h01);
		dev(1'b1, cfg_pkg::REG_PAGE, 8'hE7);
		dev(1'b1, cfg_pkg::REG_PAGE, 8'hE8);
		dev(1'b0, cfg_pkg::REG_PAGE, 8'h00);
		chk(v, 8'hE7);
		rdy();
		dev(1'b1, cfg_pkg::REG_CMD, cfg_pkg::CMD_CLEAR);
		for (int i = 0; i < 32; i++) begin
			q.push_back(8'($urandom));
			dev(1'b1, cfg_pkg::REG_BUF, q[i]);
		end
		dev(1'b1, cfg_pkg::REG_CMD, cfg_pkg::CMD_WRITE);
		rdy();
		dev(1'b1, cfg_pkg::REG_PERMIT, 8'h00);
		// Without permit a write command must not start the engine
		dev(1'b1, cfg_pkg::REG_CMD, cfg_pkg::CMD_WRITE);
		dev(1'b0, cfg_pkg::REG_CMD, 8'h00);
		chk(v & 8'h83, 8'h80);
		for (int i = 0; i < 32; i++) chk(mem[13'h1CE0 + i], q.pop_front());
		dev(1'b1, cfg_pkg::REG_CMD, cfg_pkg::CMD_CLEAR);
		dev(1'b1, cfg_pkg::REG_BUF, 8'h5A);
		dev(1'b1, cfg_pkg::REG_PAGE, 8'h00);
		dev(1'b1, cfg_pkg::REG_CMD, cfg_pkg::CMD_READ);
		rdy();
		for (int i = 0; i < 32; i++) begin
			dev(1'b0, cfg_pkg::REG_BUF, 8'h00);
			chk(v, mem[i]);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk({7'h00, se}, 8'h01);
		finish_test();
	end
endmodule // config_pump_and_nvm_page_access_tb
